// file: inc/pstc_pkg.sv
// Package of constants and types for the operating point transition controller
package pstc_pkg;

    // ******************************************************************
    // Widths and counts
    // ******************************************************************
    localparam int          NUM_CORES    = 4;       // Cores sharing one operating point
    localparam int          PSTATE_W     = 6;       // Frequency ratio width
    localparam int          VID_W        = 8;       // Voltage code width
    localparam int          CNT_W        = 8;       // Settle counter width
    localparam logic [5:0]  BOOST_BINS   = 6'h02;   // Thermal boost at most two bins
    localparam logic [5:0]  VEC_DROP     = 6'h02;   // Bins removed under heavy vector load
    localparam logic [5:0]  RESET_RATIO  = 6'h08;   // Ratio after reset
    localparam logic [7:0]  RESET_VID    = 8'h40;   // Voltage code after reset

    // ******************************************************************
    // Voltage table: base code plus per-bin slope plus per-core step
    // ******************************************************************
    localparam logic [7:0]  VID_BASE     = 8'h20;   // Code at ratio zero, no active cores
    localparam logic [7:0]  VID_PER_BIN  = 8'h02;   // Code per ratio bin
    localparam logic [7:0]  VID_PER_CORE = 8'h01;   // Extra code per added active core
    localparam logic [7:0]  VID_STEP     = 8'h01;   // Ramp step, one code per step

    // ******************************************************************
    // Timing, at 25 MHz
    // ******************************************************************
    localparam int          CLK_MHZ      = 25;      // Core clock rate
    localparam int          RAMP_STEP_NS = 200;     // Least time per voltage step
    localparam int          LOCK_NS      = 2000;    // Least PLL lock wait
    localparam logic [7:0]  RAMP_CYC     = 8'((RAMP_STEP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0]  LOCK_CYC     = 8'((LOCK_NS * CLK_MHZ + 999) / 1000);

    // ******************************************************************
    // Sequencer states
    // ******************************************************************
    typedef enum logic [3:0] {
        PSTC_IDLE = 4'h1,   // Steady at current point
        PSTC_VOLT = 4'h2,   // Ramping voltage
        PSTC_LOCK = 4'h4,   // PLL relocking
        PSTC_DONE = 4'h8    // Publish completion
    } pstc_state_type;

endpackage : pstc_pkg

// file: hdl/pstc_target_resolve.sv
// Combinational resolver of per-core requests into one target ratio and voltage
module pstc_target_resolve (
    input  wire logic [pstc_pkg::NUM_CORES*6-1:0] core_ratio,
    input  wire logic [pstc_pkg::NUM_CORES-1:0]   core_active,
    input  wire logic                             auto_mode,
    input  wire logic [5:0]                       auto_ratio,
    input  wire logic [5:0]                       min_ratio,
    input  wire logic [5:0]                       max_ratio,
    input  wire logic [5:0]                       turbo_ratio,
    input  wire logic                             thermal_ok,
    input  wire logic                             vec_heavy,
    output logic      [5:0]                       tgt_ratio,
    output logic      [7:0]                       tgt_vid
);

    // ******************************************************************
    // Per-core maximum over active cores
    // ******************************************************************
    logic [5:0] run_max [pstc_pkg::NUM_CORES+1];    // Running maximum chain
    logic [7:0] run_cnt [pstc_pkg::NUM_CORES+1];    // Running active count
    assign run_max[0] = 6'h00;
    assign run_cnt[0] = 8'h00;

    genvar g;
    generate
        for (g = 0; g < pstc_pkg::NUM_CORES; g++) begin : g_core
            // Highest request among active cores wins [R4]
            assign run_max[g+1] = (core_active[g] && core_ratio[g*6 +: 6] > run_max[g]) ?
                                  core_ratio[g*6 +: 6] : run_max[g];
            assign run_cnt[g+1] = run_cnt[g] + {7'h00, core_active[g]};
        end
    endgenerate

    // ******************************************************************
    // Policy, boost, limits and voltage choice
    // ******************************************************************
    always_comb begin
        logic [6:0] lim;     // Ceiling with boost
        logic [6:0] r;       // Working ratio
        lim = {1'b0, turbo_ratio};
        r   = {1'b0, run_max[pstc_pkg::NUM_CORES]};
        // Hardware policy picks its own point within software bounds [R9] [R10]
        if (auto_mode) begin
            r   = {1'b0, auto_ratio};
            lim = {1'b0, max_ratio};
            if (!thermal_ok && r > {1'b0, min_ratio}) begin
                r = {1'b0, min_ratio};                          // Thermal limit [R10]
            end
            if (r < {1'b0, min_ratio}) begin
                r = {1'b0, min_ratio};
            end
        end
        // Up to two bins above turbo when cool, outside autonomous mode [R8]
        if (thermal_ok && !auto_mode) begin
            lim = {1'b0, turbo_ratio} + {1'b0, pstc_pkg::BOOST_BINS};
        end
        // Heavy vector current pulls frequency down [R11]
        if (vec_heavy) begin
            lim = (lim > {1'b0, pstc_pkg::VEC_DROP}) ? lim - {1'b0, pstc_pkg::VEC_DROP} : 7'h00;
        end
        if (r > lim) begin
            r = lim;
        end
        if (r > 7'h3f) begin
            r = 7'h3f;
        end
        tgt_ratio = r[5:0];
        // Voltage from target ratio and number of active cores [R2]
        tgt_vid   = pstc_pkg::VID_BASE + 8'(pstc_pkg::VID_PER_BIN * {2'h0, r[5:0]})
                    + 8'(pstc_pkg::VID_PER_CORE * run_cnt[pstc_pkg::NUM_CORES]);
    end

endmodule // pstc_target_resolve

// file: hdl/pstc_ctrl.sv
// Operating point transition sequencer: voltage ramp then PLL lock
// Functional notes
// [R1] Several points; software picks via request registers
// [R2] Voltage from target ratio and active cores
// [R3] Voltage settles before PLL relocks
// [R4] Shared point: highest active core request wins
// [R5] Requests accepted in any cycle
// [R6] Requests during transition wait until completion
// [R7] Voltage ramps stepwise at limited rate
// [R8] Cool die: up to two bins boost; the code boosts only outside autonomous mode
// [R9] Autonomous mode: hardware picks the point
// [R10] Autonomous choice respects bounds and thermals
// [R11] Heavy vector current lowers frequency
// [R12] Only latest pending request is kept
module pstc_ctrl (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic [pstc_pkg::NUM_CORES*6-1:0] core_ratio,
    input  wire logic [pstc_pkg::NUM_CORES-1:0]   core_active,
    input  wire logic                             req_strobe,
    input  wire logic                             auto_mode,
    input  wire logic [5:0]                       auto_ratio,
    input  wire logic [5:0]                       min_ratio,
    input  wire logic [5:0]                       max_ratio,
    input  wire logic [5:0]                       turbo_ratio,
    input  wire logic                             thermal_ok,
    input  wire logic                             vec_heavy,
    input  wire logic                             pll_locked,
    output logic      [7:0]                       vid_out,
    output logic      [5:0]                       pll_ratio,
    output logic                                  pll_relock,
    output logic                                  busy,
    output logic                                  pending,
    output logic                                  done_pulse,
    output logic                                  thermal_bin_boost
);

    // ******************************************************************
    // Operation overview
    // ******************************************************************
    // A request starts a transition only from the steady state.
    // The target is resolved from the inputs in the start cycle.
    // The voltage walks one code per ramp interval to its goal.
    // Only a settled voltage lets the PLL ratio change.
    // The PLL then gets a least lock wait plus its lock flag.
    // Completion is one pulse; a held request restarts at once.
    // Requests seen mid-transition collapse into one held flag.
    // Hazard: a PLL that never locks keeps the block busy.
    // Trade: no abort path, so an old target always finishes.
    // Timing at the clock rate:
    //   start edge         -> busy high, ramp counter loaded
    //   each ramp interval -> at most one voltage code step
    //   settled voltage    -> ratio moves, relock pulse
    //   least lock wait    -> then lock flag is honoured
    //   lock seen          -> completion pulse, busy low
    // Limitation: the target is not revisited mid-walk, so
    // a changed core mask only takes effect at the next start.

    // ******************************************************************
    // Declarations
    // ******************************************************************
    // Resolver results, valid every cycle
    logic [5:0]                 tgt_ratio;          // Resolved ratio
    logic [7:0]                 tgt_vid;            // Resolved voltage
    // Sequencer state, one-hot
    pstc_pkg::pstc_state_type   state_reg, state_next;      // Sequencer state
    // Voltage side of the operating point
    logic [7:0]                 vid_reg, vid_next;          // Present voltage code
    logic [7:0]                 goal_vid_reg, goal_vid_next;    // Voltage goal of transition
    // Frequency side of the operating point
    logic [5:0]                 ratio_reg, ratio_next;      // Present PLL ratio
    logic [5:0]                 goal_ratio_reg, goal_ratio_next;    // Ratio goal of transition
    // Shared interval counter for ramp and lock waits
    logic [7:0]                 cnt_reg, cnt_next;          // Settle counter
    // Status and strobes seen outside
    logic                       busy_reg, busy_next;        // Transition in progress
    logic                       pend_reg, pend_next;        // Deferred request flag
    logic                       relock_reg, relock_next;    // PLL relock request
    logic                       done_reg, done_next;        // Completion pulse
    logic                       boost_reg, boost_next;      // Boost active flag

    // ******************************************************************
    // Target resolution
    // ******************************************************************
    // Purely combinational; its outputs matter only in a start cycle
    pstc_target_resolve u_resolve (
        .core_ratio  (core_ratio),
        .core_active (core_active),
        .auto_mode   (auto_mode),
        .auto_ratio  (auto_ratio),
        .min_ratio   (min_ratio),
        .max_ratio   (max_ratio),
        .turbo_ratio (turbo_ratio),
        .thermal_ok  (thermal_ok),
        .vec_heavy   (vec_heavy),
        .tgt_ratio   (tgt_ratio),
        .tgt_vid     (tgt_vid)
    );

    // ******************************************************************
    // Next-state logic
    // ******************************************************************
    always_comb begin
        state_next      = state_reg;
        vid_next        = vid_reg;
        goal_vid_next   = goal_vid_reg;
        ratio_next      = ratio_reg;
        goal_ratio_next = goal_ratio_reg;
        cnt_next        = cnt_reg;
        pend_next       = pend_reg;
        relock_next     = 1'b0;
        done_next       = 1'b0;
        // Boost flag follows the published ratio
        boost_next      = ratio_reg > turbo_ratio;
        case (state_reg)
            // Steady state, waiting for work
            pstc_pkg::PSTC_IDLE: begin
                // Start on a new request, or one held from before [R1] [R5] [R6]
                // A held request also uses the present inputs
                if (req_strobe || pend_reg) begin
                    pend_next       = 1'b0;
                    goal_ratio_next = tgt_ratio;    // Target sampled now [R12]
                    goal_vid_next   = tgt_vid;
                    cnt_next        = pstc_pkg::RAMP_CYC;
                    state_next      = pstc_pkg::PSTC_VOLT;
                end
            end
            // Voltage walk toward the goal code
            pstc_pkg::PSTC_VOLT: begin
                // One code step per ramp interval [R7]
                if (cnt_reg > 8'h01) begin
                    // Still inside the present ramp interval
                    cnt_next = cnt_reg - 8'h01;
                end else if (vid_reg < goal_vid_reg) begin
                    // Goal above: one step up, interval restarts
                    vid_next = vid_reg + pstc_pkg::VID_STEP;    // [R7]
                    cnt_next = pstc_pkg::RAMP_CYC;
                end else if (vid_reg > goal_vid_reg) begin
                    // Goal below: one step down, interval restarts
                    vid_next = vid_reg - pstc_pkg::VID_STEP;    // [R7]
                    cnt_next = pstc_pkg::RAMP_CYC;
                end else begin
                    // Voltage settled, only now retarget PLL [R3]
                    ratio_next  = goal_ratio_reg;
                    relock_next = 1'b1;
                    cnt_next    = pstc_pkg::LOCK_CYC;
                    state_next  = pstc_pkg::PSTC_LOCK;
                end
            end
            // PLL relocking onto the new ratio
            pstc_pkg::PSTC_LOCK: begin
                // Least lock wait, then wait for lock indication [R3]
                if (cnt_reg > 8'h00) begin
                    // Lock flag ignored until the least wait is over
                    cnt_next = cnt_reg - 8'h01;
                end else if (pll_locked) begin
                    // Locked: new point reached
                    state_next = pstc_pkg::PSTC_DONE;
                end
            end
            // One cycle to publish completion
            pstc_pkg::PSTC_DONE: begin
                done_next  = 1'b1;
                state_next = pstc_pkg::PSTC_IDLE;
            end
            // Stray code: fall back to the steady state
            default: begin
                state_next = pstc_pkg::PSTC_IDLE;
            end
        endcase
        // Requests during a transition deferred; newest wins at restart [R6] [R12]
        // A strobe in the steady state starts at once instead
        if (req_strobe && state_reg != pstc_pkg::PSTC_IDLE) begin
            pend_next = 1'b1;
        end
        // Busy leaves the same flop stage as the state itself
        busy_next = (state_next != pstc_pkg::PSTC_IDLE);
    end

    // ******************************************************************
    // State registers
    // ******************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Start point after reset, no work held
            state_reg      <= pstc_pkg::PSTC_IDLE;
            vid_reg        <= pstc_pkg::RESET_VID;
            goal_vid_reg   <= pstc_pkg::RESET_VID;
            ratio_reg      <= pstc_pkg::RESET_RATIO;
            goal_ratio_reg <= pstc_pkg::RESET_RATIO;
            cnt_reg        <= 8'h00;
            busy_reg       <= 1'b0;
            pend_reg       <= 1'b0;
            relock_reg     <= 1'b0;
            done_reg       <= 1'b0;
            boost_reg      <= 1'b0;
        end else begin
            // Every register takes its next value
            state_reg      <= state_next;
            vid_reg        <= vid_next;
            goal_vid_reg   <= goal_vid_next;
            ratio_reg      <= ratio_next;
            goal_ratio_reg <= goal_ratio_next;
            cnt_reg        <= cnt_next;
            busy_reg       <= busy_next;
            pend_reg       <= pend_next;
            relock_reg     <= relock_next;
            done_reg       <= done_next;
            boost_reg      <= boost_next;
        end
    end

    // ******************************************************************
    // Outputs straight from flip-flops
    // ******************************************************************
    // All status is registered so the far side sees clean levels
    assign vid_out           = vid_reg;
    assign pll_ratio         = ratio_reg;
    assign pll_relock        = relock_reg;
    assign busy              = busy_reg;
    assign pending           = pend_reg;
    assign done_pulse        = done_reg;
    assign thermal_bin_boost = boost_reg;

endmodule // pstc_ctrl

// file: tb/pstc_pll_model.sv
// Behavioural PLL that reports lock a set number of cycles after each relock
module pstc_pll_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pll_relock,
    input  wire logic [7:0] lock_delay,
    output logic            pll_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_reg;  // Cycles left until lock
    // Lock drops on relock and returns after the chosen delay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg   <= 8'h00;
            pll_locked <= 1'b1;
        end else if (pll_relock) begin
            wait_reg   <= lock_delay;
            pll_locked <= 1'b0;
        end else if (wait_reg != 8'h00) begin
            wait_reg <= wait_reg - 8'h01;
        end else begin
            pll_locked <= 1'b1;
        end
    end
endmodule // pstc_pll_model

// file: tb/pstc_ctrl_monitor.sv
// Port checker for the transition sequencer
module pstc_ctrl_monitor (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       req_strobe,
    input wire logic       auto_mode,
    input wire logic [5:0] turbo_ratio,
    input wire logic [7:0] vid_out,
    input wire logic [5:0] pll_ratio,
    input wire logic       pll_relock,
    input wire logic       busy,
    input wire logic       pending,
    input wire logic       done_pulse,
    input wire logic       thermal_bin_boost
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] age_reg;   // Cycles since last relock, saturating
    logic [7:0] age_next;
    // Age counter next value
    always_comb begin
        age_next = (age_reg == 8'hff) ? age_reg : age_reg + 8'h01;
        if (pll_relock) begin
            age_next = 8'h00;
        end
    end
    // Age counter register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            age_reg <= 8'hff;
        end else begin
            age_reg <= age_next;
        end
    end
    AST_RELOCK_ONE: assert property (pll_relock |=> !pll_relock)
        else $error("relock pulse longer than one cycle");
    AST_DONE_ONE: assert property (done_pulse |=> !done_pulse)
        else $error("done pulse longer than one cycle");
    AST_RATIO_AFTER_VOLT: assert property ($changed(pll_ratio) |-> pll_relock && $stable(vid_out))
        else $error("ratio moved without relock or with voltage moving");
    AST_VID_STEP: assert property ($changed(vid_out) |->
        vid_out == $past(vid_out) + 8'h01 || vid_out == $past(vid_out) - 8'h01)
        else $error("voltage jumped more than one code");
    AST_VID_SPACING: assert property ($changed(vid_out) |=> $stable(vid_out) [*4])
        else $error("voltage steps too close together");
    AST_LOCK_WAIT: assert property (done_pulse |-> age_reg >= pstc_pkg::LOCK_CYC)
        else $error("completion before lock wait elapsed");
    AST_START: assert property (req_strobe && !busy |=> busy)
        else $error("idle request not started");
    AST_PENDING_GO: assert property (pending && !busy |=> busy)
        else $error("held request not started");
    AST_BOOST_CAP: assert property (!auto_mode && !busy |-> pll_ratio <= turbo_ratio + 6'h02)
        else $error("ratio above boosted ceiling");
    cover property (pending && done_pulse);
    cover property (thermal_bin_boost && done_pulse);
    cover property (auto_mode && done_pulse);
endmodule // pstc_ctrl_monitor
bind pstc_ctrl pstc_ctrl_monitor u_mon (.clk(clk), .rst(rst), .req_strobe(req_strobe), .auto_mode(auto_mode),
    .turbo_ratio(turbo_ratio), .vid_out(vid_out), .pll_ratio(pll_ratio), .pll_relock(pll_relock), .busy(busy),
    .pending(pending), .done_pulse(done_pulse), .thermal_bin_boost(thermal_bin_boost));

// file: tb/pstc_ctrl_tb_top.sv
// Testbench of the transition sequencer with a PLL model
module pstc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, req_strobe, auto_mode, thermal_ok, vec_heavy, pll_locked;
    logic [23:0] core_ratio;  // Per-core requests
    logic [3:0]  core_active; // Active core mask
    logic [5:0]  auto_ratio, min_ratio, max_ratio, turbo_ratio, pll_ratio;
    logic [7:0]  vid_out, lock_delay;
    logic        pll_relock, busy, pending, done_pulse, thermal_bin_boost;
    int          n_fail, n_tests;
    pstc_ctrl dut (.clk(clk), .rst(rst), .core_ratio(core_ratio), .core_active(core_active),
        .req_strobe(req_strobe), .auto_mode(auto_mode), .auto_ratio(auto_ratio), .min_ratio(min_ratio),
        .max_ratio(max_ratio), .turbo_ratio(turbo_ratio), .thermal_ok(thermal_ok), .vec_heavy(vec_heavy),
        .pll_locked(pll_locked), .vid_out(vid_out), .pll_ratio(pll_ratio), .pll_relock(pll_relock),
        .busy(busy), .pending(pending), .done_pulse(done_pulse), .thermal_bin_boost(thermal_bin_boost));
    pstc_pll_model u_pll (.clk(clk), .rst(rst), .pll_relock(pll_relock), .lock_delay(lock_delay),
        .pll_locked(pll_locked));
    // Expected voltage code for a ratio and active core count
    function automatic logic [7:0] vid_of(input logic [5:0] r, input int n);
        return pstc_pkg::VID_BASE + 8'(r) * pstc_pkg::VID_PER_BIN + 8'(n) * pstc_pkg::VID_PER_CORE;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic strobe;
        @(posedge clk) req_strobe <= 1'b1;
        @(posedge clk) req_strobe <= 1'b0;
    endtask
    // Wait for completion pulse, bounded
    task automatic wait_done;
        int i;
        int n_rl;   // Relock pulses seen during this wait
        i = 0;
        n_rl = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
            if (pll_relock === 1'b1) n_rl++;
        end while (done_pulse !== 1'b1 && i < 3000);
        check(8'({done_pulse, busy}), 8'h02);
        check(8'(n_rl), 8'h01);
    endtask
    task automatic go(input logic [5:0] r, input int n);
        strobe();
        wait_done();
        check(8'(pll_ratio), 8'(r));
        check(vid_out, vid_of(r, n));
    endtask
    task automatic t_reset;
        check(vid_out, pstc_pkg::RESET_VID);
        check(8'(pll_ratio), 8'(pstc_pkg::RESET_RATIO));
        check(8'({busy, pending}), 8'h00);
        $display("reset test done");
    endtask
    task automatic t_resolve;
        @(posedge clk) core_ratio <= {6'h06, 6'h1a, 6'h10, 6'h0c};
        core_active <= 4'b1011;
        go(6'h10, 3);
        @(posedge clk) core_active <= 4'b1111;
        go(6'h1a, 4);
        $display("resolve test done");
    endtask
    task automatic t_boost;
        @(posedge clk) core_ratio <= {4{6'h3f}};
        core_active <= 4'b0001;
        thermal_ok <= 1'b1;
        go(6'h22, 1);
        check(8'(thermal_bin_boost), 8'h01);
        @(posedge clk) thermal_ok <= 1'b0;
        go(6'h20, 1);
        check(8'(thermal_bin_boost), 8'h00);
        @(posedge clk) vec_heavy <= 1'b1;
        go(6'h1e, 1);
        @(posedge clk) vec_heavy <= 1'b0;
        $display("boost test done");
    endtask
    // Three back-to-back requests under a slow PLL
    task automatic t_defer;
        lock_delay <= 8'd90;
        @(posedge clk) core_ratio <= {4{6'h0c}};
        req_strobe <= 1'b1;
        @(posedge clk) core_ratio <= {4{6'h14}};
        @(posedge clk) core_ratio <= {4{6'h16}};
        @(posedge clk) req_strobe <= 1'b0;
        #1;
        check(8'({busy, pending}), 8'h03);
        wait_done();
        check(8'(pll_ratio), 8'h0c);
        wait_done();
        check(8'(pll_ratio), 8'h16);
        check(vid_out, vid_of(6'h16, 1));
        lock_delay <= 8'd10;
        $display("defer test done");
    endtask
    task automatic t_auto;
        logic [5:0] req [4] = '{6'h30, 6'h04, 6'h10, 6'h10};
        logic [5:0] exp [4] = '{6'h18, 6'h08, 6'h10, 6'h08};
        @(posedge clk) auto_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) auto_ratio <= req[i];
            thermal_ok <= (i != 3);
            go(exp[i], 1);
        end
        $display("auto test done");
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial begin
        {rst, req_strobe, auto_mode, thermal_ok, vec_heavy} = 5'h10;
        {core_ratio, core_active, auto_ratio} = '0;
        {min_ratio, max_ratio, turbo_ratio} = {6'h08, 6'h18, 6'h20};
        lock_delay = 8'd10;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_resolve();
        t_boost();
        t_defer();
        t_auto();
        summarize();
    end
endmodule // pstc_ctrl_tb_top
